// ### hw/tbh_attrib_halt.sv
`timescale 1ns/1ps
`default_nettype none
module tbh_attrib_halt
  import tbh_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [31:0] tag_pupi,
  input  wire logic        wake_req,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_end,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output logic             tx_carrier,
  output logic             tx_sof_en,
  output logic             tx_eof_en,
  output logic             tag_active,
  output logic             tag_halted,
  output logic [1:0]       link_rate,
  output logic [3:0]       reader_frame_code
);

  ////////////////////////////////////////////////////////////////////////////////
  // received frame

  tbh_crc_if crc_bus ();

  tbh_crc_engine u_crc (
    .clock (clock),
    .reset (reset),
    .crc   (crc_bus)
  );

  tbh_tag_t    tag_reg;
  tbh_phase_t  phase_reg;
  logic [7:0]  frame_reg [0:10];
  logic [3:0]  count_reg;
  logic [15:0] tail_reg;
  logic [11:0] timer_reg;
  logic [1:0]  byte_idx_reg;
  logic [7:0]  reply_reg;
  logic [15:0] reply_crc_reg;
  logic [7:0]  tx_data_reg;
  logic [1:0]  rate_reg;
  logic [3:0]  frame_code_reg;

  logic crc_ok;
  logic pupi_ok;
  logic attrib_hit;
  logic halt_hit;
  logic rx_byte;
  logic tx_step;

  function automatic logic params_ok(input logic [7:0] p2, input logic [7:0] p3,
                                     input logic [7:0] p4);
    return (p2[7:6] == p2[5:4])
         && (p2[7:6] != RATE_RSVD)
         && (p2[3:0] <= FRAME_MAX)
         && (p3[7:4] == RFU_NIBBLE) && p3[0]
         && (p4[3:0] == NO_CID);
  endfunction : params_ok

  // frames arriving while an answer is pending are not looked at
  assign rx_byte = rx_valid && (phase_reg == PH_RX);

  // the last two bytes are the crc, so the engine runs two bytes behind
  assign crc_bus.clear = reset || (rx_end && phase_reg == PH_RX);
  assign crc_bus.step  = rx_byte && (count_reg >= 4'h2);
  assign crc_bus.data  = tail_reg[15:8];

  assign crc_ok  = (~crc_bus.value == {tail_reg[7:0], tail_reg[15:8]});
  assign pupi_ok = ({frame_reg[IDX_PUPI], frame_reg[IDX_PUPI + 1], frame_reg[IDX_PUPI + 2],
                     frame_reg[IDX_PUPI + 3]} == tag_pupi);

  assign attrib_hit = rx_end && (phase_reg == PH_RX) && crc_ok && pupi_ok
                   && (count_reg == ATTRIB_LEN) && (frame_reg[IDX_CMD] == ATTRIB_CODE)
                   && (tag_reg != TS_HALT)
                   && params_ok(frame_reg[IDX_P2], frame_reg[IDX_P3], frame_reg[IDX_P4]);
  assign halt_hit   = rx_end && (phase_reg == PH_RX) && crc_ok && pupi_ok
                   && (count_reg == HALT_LEN) && (frame_reg[IDX_CMD] == HALT_CODE)
                   && (tag_reg != TS_HALT);

  always_ff @(posedge clock)
  begin
    if (reset || (rx_end && phase_reg == PH_RX))
    begin
      count_reg <= 4'h0;
      tail_reg  <= 16'h0000;
    end
    else if (rx_byte)
    begin
      if (count_reg != FRAME_OVER)
        count_reg <= count_reg + 4'h1;
      tail_reg <= {tail_reg[7:0], rx_data};
    end
  end

  // storage keeps no reset; count_reg alone decides what is valid
  always_ff @(posedge clock)
  begin
    if (rx_byte && count_reg < ATTRIB_LEN)
      frame_reg[count_reg] <= rx_data;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protocol state

  always_ff @(posedge clock)
  begin
    if (reset)
      tag_reg <= TS_IDLE;
    else if (halt_hit)
      tag_reg <= TS_HALT;
    else if (attrib_hit)
      tag_reg <= TS_ACTIVE;
    else if (wake_req && tag_reg == TS_HALT)
      tag_reg <= TS_IDLE;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rate_reg       <= 2'h0;
      frame_code_reg <= 4'h0;
    end
    else if (attrib_hit)
    begin
      rate_reg       <= frame_reg[IDX_P2][7:6];
      frame_code_reg <= frame_reg[IDX_P2][3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // answer: tr0 quiet, tr1 carrier, then three bytes

  assign tx_step = (phase_reg == PH_TX) && tx_ready;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      phase_reg     <= PH_RX;
      timer_reg     <= 12'h000;
      byte_idx_reg  <= 2'h0;
      reply_reg     <= HALT_REPLY;
      reply_crc_reg <= HALT_CRC;
      tx_data_reg   <= 8'h00;
    end
    else
    begin
      case (phase_reg)
        PH_RX:
        begin
          if (attrib_hit || halt_hit)
          begin
            phase_reg     <= PH_TR0;
            timer_reg     <= TR0_CYC - 12'h001;
            reply_reg     <= halt_hit ? HALT_REPLY : ATTRIB_REPLY;
            reply_crc_reg <= halt_hit ? HALT_CRC : ATTRIB_CRC;
          end
        end
        PH_TR0:
        begin
          if (timer_reg == 12'h000)
          begin
            phase_reg <= PH_TR1;
            timer_reg <= TR1_CYC - 12'h001;
          end
          else
            timer_reg <= timer_reg - 12'h001;
        end
        PH_TR1:
        begin
          if (timer_reg == 12'h000)
          begin
            phase_reg    <= PH_TX;
            byte_idx_reg <= 2'h0;
            tx_data_reg  <= reply_reg;
          end
          else
            timer_reg <= timer_reg - 12'h001;
        end
        PH_TX:
        begin
          if (tx_step)
          begin
            byte_idx_reg <= byte_idx_reg + 2'h1;
            tx_data_reg  <= (byte_idx_reg == 2'h0) ? reply_crc_reg[7:0] : reply_crc_reg[15:8];
            if (byte_idx_reg == 2'h2)
              phase_reg <= PH_RX;
          end
        end
        default:
          phase_reg <= PH_RX;
      endcase
    end
  end

  assign tx_valid          = (phase_reg == PH_TX);
  assign tx_last           = (phase_reg == PH_TX) && (byte_idx_reg == 2'h2);
  assign tx_data           = tx_data_reg;
  // carrier stays up through the bytes; the front end frames them
  assign tx_carrier        = (phase_reg == PH_TR1) || (phase_reg == PH_TX);
  // start and end marks are never omitted, whatever param1 asks
  assign tx_sof_en         = 1'b1;
  assign tx_eof_en         = 1'b1;
  assign tag_active        = (tag_reg == TS_ACTIVE);
  assign tag_halted        = (tag_reg == TS_HALT);
  assign link_rate         = rate_reg;
  assign reader_frame_code = frame_code_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic        attrib_frame;
  logic [12:0] gap_reg;

  assign attrib_frame = rx_end && phase_reg == PH_RX && count_reg == ATTRIB_LEN
                     && frame_reg[IDX_CMD] == ATTRIB_CODE;

  always_ff @(posedge clock)
  begin
    if (reset || phase_reg == PH_RX)
      gap_reg <= 13'h0000;
    else if (phase_reg != PH_TX)
      gap_reg <= gap_reg + 13'h0001;
  end

  a_rate_differs: assert property (@(posedge clock) disable iff (reset)
    attrib_frame && frame_reg[IDX_P2][7:6] != frame_reg[IDX_P2][5:4] |=> phase_reg == PH_RX)
    else $error("answered attrib with unequal rates");
  a_rate_reserved: assert property (@(posedge clock) disable iff (reset)
    attrib_frame && frame_reg[IDX_P2][7:6] == RATE_RSVD |=> (phase_reg == PH_RX) [*3])
    else $error("answered attrib with reserved rate");
  a_frame_size: assert property (@(posedge clock) disable iff (reset)
    attrib_frame && frame_reg[IDX_P2][3:0] > FRAME_MAX |=> phase_reg == PH_RX
    && $stable(tag_reg))
    else $error("answered attrib with unsupported frame size");
  a_proto_type: assert property (@(posedge clock) disable iff (reset)
    attrib_frame && (frame_reg[IDX_P3][7:4] != 4'h0 || !frame_reg[IDX_P3][0])
    |=> phase_reg == PH_RX && $stable(tag_reg))
    else $error("answered attrib with bad protocol byte");
  a_cid_zero: assert property (@(posedge clock) disable iff (reset)
    attrib_frame && frame_reg[IDX_P4][3:0] != NO_CID |=> phase_reg == PH_RX)
    else $error("answered attrib with card identifier");
  a_reply_byte: assert property (@(posedge clock) disable iff (reset)
    $rose(tx_valid) |-> tx_data == (tag_halted ? HALT_REPLY : ATTRIB_REPLY))
    else $error("wrong first answer byte");
  a_halt_entry: assert property (@(posedge clock) disable iff (reset)
    halt_hit |=> tag_halted && phase_reg == PH_TR0)
    else $error("halt not taken");
  a_attrib_entry: assert property (@(posedge clock) disable iff (reset)
    attrib_hit |=> tag_active && phase_reg == PH_TR0)
    else $error("attrib not taken");
  a_guard_time: assert property (@(posedge clock) disable iff (reset)
    $rose(tx_valid) |-> gap_reg == {1'b0, TR0_CYC} + {1'b0, TR1_CYC})
    else $error("answer guard time wrong");
  a_crc_drop: assert property (@(posedge clock) disable iff (reset)
    rx_end && phase_reg == PH_RX && !crc_ok |=> phase_reg == PH_RX && $stable(tag_reg))
    else $error("frame with bad crc acted upon");

endmodule : tbh_attrib_halt
`default_nettype wire

// ### inc/tbh_pkg.sv
package tbh_pkg;

  // command and answer codes
  localparam logic [7:0] ATTRIB_CODE  = 8'h1d;
  localparam logic [7:0] HALT_CODE    = 8'h50;
  localparam logic [3:0] ATTRIB_MBLI  = 4'h1;
  localparam logic [3:0] NO_CID       = 4'h0;
  localparam logic [7:0] ATTRIB_REPLY = {ATTRIB_MBLI, NO_CID};
  localparam logic [7:0] HALT_REPLY   = 8'h00;

  // frame layout, byte positions from the command code
  localparam logic [3:0] ATTRIB_LEN = 4'hb;
  localparam logic [3:0] HALT_LEN   = 4'h7;
  localparam logic [3:0] FRAME_OVER = 4'hc;
  localparam int         IDX_CMD    = 0;
  localparam int         IDX_PUPI   = 1;
  localparam int         IDX_P2     = 6;
  localparam int         IDX_P3     = 7;
  localparam int         IDX_P4     = 8;

  // parameter fields
  localparam logic [1:0] RATE_RSVD   = 2'h3;
  localparam logic [3:0] FRAME_MAX   = 4'h8;
  localparam logic [3:0] RFU_NIBBLE  = 4'h0;

  // crc_b: reflected ccitt, preset ones, complemented on the air
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;

  // response guard times in subcarrier periods
  localparam longint FS_HZ    = 848000;
  localparam longint CLK_HZ   = 40000000;
  localparam longint TR0_FS   = 64;
  localparam longint TR1_FS   = 80;
  localparam logic [11:0] TR0_CYC = 12'((TR0_FS * CLK_HZ + FS_HZ - 1) / FS_HZ);
  localparam logic [11:0] TR1_CYC = 12'((TR1_FS * CLK_HZ + FS_HZ - 1) / FS_HZ);

  typedef enum logic [1:0] {TS_IDLE, TS_ACTIVE, TS_HALT} tbh_tag_t;
  typedef enum logic [1:0] {PH_RX, PH_TR0, PH_TR1, PH_TX} tbh_phase_t;

  function automatic logic [15:0] crc_b_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_b_byte

  localparam logic [15:0] ATTRIB_CRC = ~crc_b_byte(CRC_INIT, ATTRIB_REPLY);
  localparam logic [15:0] HALT_CRC   = ~crc_b_byte(CRC_INIT, HALT_REPLY);

endpackage : tbh_pkg

// ### inc/tbh_crc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tbh_crc_if;
  logic        clear;
  logic        step;
  logic [7:0]  data;
  logic [15:0] value;
  modport engine (input clear, input step, input data, output value);
  modport user   (output clear, output step, output data, input value);
endinterface : tbh_crc_if
`default_nettype wire

// ### hw/tbh_crc_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tbh_crc_engine
  import tbh_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  reset,
  tbh_crc_if.engine  crc
);

  logic [15:0] crc_reg;

  // clear wins over step: a new frame never inherits the old remainder
  always_ff @(posedge clock)
  begin
    if (reset || crc.clear)
      crc_reg <= CRC_INIT;
    else if (crc.step)
      crc_reg <= crc_b_byte(crc_reg, crc.data);
  end

  assign crc.value = crc_reg;

endmodule : tbh_crc_engine
`default_nettype wire

// ### tb/tbh_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module tbh_reader_model
(
  input  wire logic       clock,
  input  wire logic       slow,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_end,
  output logic            tx_ready
);
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_end   = 1'b0;
  end

  function automatic logic [15:0] crc_b(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (f[i])
    begin
      c = c ^ {8'h00, f[i]};
      for (int k = 0; k < 8; k++)
      begin
        c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
    end
    return ~c;
  endfunction : crc_b

  ////////////////////////////////////////////////////////////////////////////
  // whole frame, crc low byte first; bad spoils the crc on purpose
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = crc_b(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i])
    begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data  <= f[i];
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data  <= ~f[f.size()-1];  // released: never leave the last byte
    @(posedge clock);
    rx_end <= 1'b1;
    @(posedge clock);
    rx_end <= 1'b0;
  endtask : send

  // slow reader stalls the answer at random
  always @(posedge clock)
    tx_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
endmodule : tbh_reader_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock;
  logic        reset;
  logic [31:0] tag_pupi;
  logic        wake_req;
  logic        slow;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_end;
  logic        tx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_last;
  logic        tx_carrier;
  logic        tx_sof_en;
  logic        tx_eof_en;
  logic        tag_active;
  logic        tag_halted;
  logic [1:0]  link_rate;
  logic [3:0]  reader_frame_code;
  logic [7:0]  exp[$];
  int          failures;
  int          num_checks;
  logic [1:0]  rt;
  logic [3:0]  fc;
  logic [15:0] carrier_cyc;
  // refused attrib: {p2, p3, p4, flags}, flag 0 spoils crc, flag 1 wrong pupi
  logic [31:0] bad_tab [8] = '{32'h10010000, 32'hf0010000, 32'h09010000, 32'h00110000,
                               32'h000e0000, 32'h00010100, 32'h00010001, 32'h00010002};

  tbh_attrib_halt tbh_attrib_halt_i (.clock(clock), .reset(reset), .tag_pupi(tag_pupi),
    .wake_req(wake_req), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_carrier(tx_carrier), .tx_sof_en(tx_sof_en), .tx_eof_en(tx_eof_en),
    .tag_active(tag_active), .tag_halted(tag_halted), .link_rate(link_rate),
    .reader_frame_code(reader_frame_code));
  tbh_reader_model reader_i (.clock(clock), .slow(slow), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .tx_ready(tx_ready));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte

  task automatic check_stat(input string nm, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check_stat

  task automatic check_cyc(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check_cyc

  // lead of the carrier over the first answer byte, as the reader sees it
  always @(posedge clock)
    if (tx_carrier !== 1'b1)
      carrier_cyc <= 16'h0000;
    else if (tx_valid !== 1'b1)
      carrier_cyc <= carrier_cyc + 16'h0001;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // answer bytes are checked as the reader takes them
  always @(posedge clock)
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      if (exp.size() == 0)
        check_stat("tx_valid", 4'h0, 4'h1);
      else
      begin
        if (exp.size() == 3)
          check_cyc("carrier lead", 16'(tbh_pkg::TR1_CYC), carrier_cyc);
        check_stat("tx_carrier", 4'h1, 4'(tx_carrier));
        check_stat("tx_last", 4'(exp.size() == 1), 4'(tx_last));
        check_byte("tx_data", exp.pop_front(), tx_data);
      end
    end

  task automatic cmd(input logic [7:0] code, input logic [31:0] prm, input logic [1:0] fl,
                     input logic ok, input logic [7:0] rep);
    logic [7:0]  f[$];
    logic [31:0] id;
    logic [15:0] c;
    id = tag_pupi ^ {31'h0, fl[1]};
    f = {code, id[31:24], id[23:16], id[15:8], id[7:0]};
    if (code == 8'h1d)
      f = {f, prm[31:24], prm[23:16], prm[15:8], prm[7:0]};
    reader_i.send(f, fl[0]);
    if (ok)
    begin
      c = reader_i.crc_b({rep});
      exp = {exp, rep, c[7:0], c[15:8]};
      for (int n = 0; n < 9000 && exp.size() > 0; n++)
        @(posedge clock);
      @(posedge clock);
      check_stat("answer left", 4'h0, 4'(exp.size()));
      check_stat("carrier off", 4'h0, 4'(tx_carrier));
    end
    else
      repeat (30) @(posedge clock);
  endtask : cmd

  initial
  begin
    repeat (60000) @(posedge clock);
    failures++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(44));
    reset = 1'b1;
    wake_req = 1'b0;
    slow = 1'b0;
    tag_pupi = $urandom;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check_stat("sof eof", 4'h3, {2'b00, tx_sof_en, tx_eof_en});
    foreach (bad_tab[i])
    begin
      cmd(8'h1d, {8'h00, bad_tab[i][31:8]}, bad_tab[i][1:0], 1'b0, 8'h00);
      check_stat("tag_active", 4'h0, 4'(tag_active));
    end
    $display("test refused attrib done");
    for (int i = 0; i < 2; i++)
    begin
      slow <= 1'(i);
      rt = 2'($urandom_range(0, 2));
      fc = (i == 0) ? 4'h8 : 4'($urandom_range(0, 8));
      cmd(8'h1d, {8'($urandom), rt, rt, fc, 4'h0, 3'($urandom), 1'b1, 4'($urandom), 4'h0},
          2'b00, 1'b1, 8'h10);
      check_stat("tag_active", 4'h1, 4'(tag_active));
      check_stat("link_rate", 4'(rt), 4'(link_rate));
      check_stat("frame code", fc, reader_frame_code);
    end
    // the spoilt frame carries a rate other than the kept one, so acting on it would show
    cmd(8'h1d, {8'h00, (rt == 2'h0) ? 4'h5 : 4'h0, 20'h00100}, 2'b01, 1'b0, 8'h00);
    check_stat("link_rate kept", 4'(rt), 4'(link_rate));
    $display("test accepted attrib done");
    cmd(8'h50, 32'h0, 2'b10, 1'b0, 8'h00);
    check_stat("tag_halted", 4'h0, 4'(tag_halted));
    cmd(8'h50, 32'h0, 2'b00, 1'b1, 8'h00);
    check_stat("tag_halted", 4'h1, 4'(tag_halted));
    cmd(8'h1d, 32'h00000100, 2'b00, 1'b0, 8'h00);
    check_stat("halt kept", 4'h1, 4'(tag_halted));
    wake_req <= 1'b1;
    @(posedge clock);
    wake_req <= 1'b0;
    repeat (2) @(posedge clock);
    check_stat("woken", 4'h0, 4'(tag_halted));
    $display("test halt done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
